/* File: inc/adc_pkg.sv */
// holds register offsets, field positions, codes and carrier types for the async context control block
// assumes an apb slave on pclk and a dma engine that reports context events on the status port
package adc_pkg;
  localparam int unsigned   adc_num_ctx      = 4;            // transmit req, transmit resp, receive req, receive resp
  localparam logic [11:0]   adc_off_txrq_set = 12'h180;      // transmit request context set port
  localparam logic [11:0]   adc_off_txrq_clr = 12'h184;      // transmit request context clear port
  localparam logic [11:0]   adc_off_txrs_set = 12'h1a0;      // transmit response context set port
  localparam logic [11:0]   adc_off_txrs_clr = 12'h1a4;      // transmit response context clear port
  localparam logic [11:0]   adc_off_rxrq_set = 12'h1c0;      // receive request context set port
  localparam logic [11:0]   adc_off_rxrq_clr = 12'h1c4;      // receive request context clear port
  localparam logic [11:0]   adc_off_rxrs_set = 12'h1e0;      // receive response context set port
  localparam logic [11:0]   adc_off_rxrs_clr = 12'h1e4;      // receive response context clear port
  localparam logic [11:0]   adc_off_irq_stat = 12'h1f0;      // sticky event status, read only
  localparam logic [11:0]   adc_off_irq_clr  = 12'h1f4;      // event clear, write only
  localparam logic [11:0]   adc_off_irq_en   = 12'h1f8;      // event enable
  localparam int unsigned   adc_bit_run      = 15;           // run bit position
  localparam int unsigned   adc_bit_wake     = 12;           // wake bit position
  localparam int unsigned   adc_bit_dead     = 11;           // dead bit position
  localparam int unsigned   adc_bit_active   = 10;           // active bit position
  localparam int unsigned   adc_spd_lsb      = 5;            // speed field low bit
  localparam int unsigned   adc_evt_lsb      = 0;            // completion code low bit
  localparam logic [2:0]    adc_spd_s100     = 3'h0;         // 100 mbit/s
  localparam logic [2:0]    adc_spd_s200     = 3'h1;         // 200 mbit/s
  localparam logic [2:0]    adc_spd_s400     = 3'h2;         // 400 mbit/s
  localparam logic [4:0]    adc_evt_reset    = 5'h00;        // completion code after reset
  localparam logic [31:0]   adc_word_zero    = 32'h0000_0000;
  localparam int unsigned   adc_ev_bits      = 3;            // events per context in the status register
  localparam int unsigned   adc_ev_dead      = 0;            // context went dead
  localparam int unsigned   adc_ev_done      = 1;            // packet completed
  localparam int unsigned   adc_ev_stop      = 2;            // context went idle

  // per-context report from the dma engine, one cycle pulses, a busy level and data
  typedef struct packed {
    logic       fetch;    // descriptor fetch performed
    logic       start;    // first fetch at command pointer taken
    logic       busy;     // engine processing descriptors
    logic       fatal;    // unrecoverable error
    logic       done;     // packet finished
    logic       ok;       // packet succeeded, code is an acknowledge
    logic [4:0] code;     // acknowledge or internal error code
    logic [2:0] spd;      // speed of the packet
  } adc_ctx_stat_t;

  // per-context control toward the dma engine
  typedef struct packed {
    logic run;            // processing allowed
    logic wake;           // re-attempt descriptor fetch
    logic start;          // pulse: begin at first descriptor
  } adc_ctx_ctrl_t;

  // decoder result for one address
  typedef struct packed {
    logic       hit;      // address is a context port
    logic       clr;      // clear port rather than set port
    logic [1:0] ctx;      // context index
  } adc_dec_t;
endpackage : adc_pkg

/* File: src/adc_ctx_ctrl.sv */
// holds the four async dma context control registers behind an apb slave, plus an event interrupt
// assumes the dma engine runs on pclk and keeps every status pulse single-cycle
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module adc_ctx_ctrl
  import adc_pkg::*;
#(
  parameter int unsigned NCTX = adc_num_ctx  // number of async contexts
)(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  soft_reset,   // software reset pulse, returns run to zero
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire adc_ctx_stat_t [3:0]   ctx_stat,     // engine reports per context
  output var  adc_ctx_ctrl_t [3:0]   ctx_ctrl,     // controls toward engine
  output var  logic                  irq
);

  // address decoding shared by read and write paths
  function automatic adc_dec_t adc_decode(input logic [11:0] a);
    adc_dec_t d;
    d = '0;
    unique case (a)
      adc_off_txrq_set: d = '{hit: 1'b1, clr: 1'b0, ctx: 2'h0};
      adc_off_txrq_clr: d = '{hit: 1'b1, clr: 1'b1, ctx: 2'h0};
      adc_off_txrs_set: d = '{hit: 1'b1, clr: 1'b0, ctx: 2'h1};
      adc_off_txrs_clr: d = '{hit: 1'b1, clr: 1'b1, ctx: 2'h1};
      adc_off_rxrq_set: d = '{hit: 1'b1, clr: 1'b0, ctx: 2'h2};
      adc_off_rxrq_clr: d = '{hit: 1'b1, clr: 1'b1, ctx: 2'h2};
      adc_off_rxrs_set: d = '{hit: 1'b1, clr: 1'b0, ctx: 2'h3};
      adc_off_rxrs_clr: d = '{hit: 1'b1, clr: 1'b1, ctx: 2'h3};
      default:          d = '0;
    endcase
    return d;
  endfunction

  // speed filter: reserved codes are never stored
  function automatic logic [2:0] adc_spd_legal(input logic [2:0] s, input logic [2:0] old);
    logic [2:0] r;
    r = old;
    if (s == adc_spd_s100 || s == adc_spd_s200 || s == adc_spd_s400)
      r = s;
    return r;
  endfunction

  logic [NCTX-1:0]          run;          // per-context run bits
  logic [NCTX-1:0]          wake;         // per-context wake bits
  logic [NCTX-1:0]          dead;         // per-context dead bits
  logic [NCTX-1:0]          active;       // per-context active mirrors
  logic [2:0]               spd    [NCTX];// last packet speed
  logic [4:0]               evcode [NCTX];// last completion code
  logic [NCTX*adc_ev_bits-1:0] irq_stat;  // sticky events
  logic [NCTX*adc_ev_bits-1:0] irq_en;    // event enables
  logic                     wr_acc;       // write in access phase
  logic                     rd_acc;       // read in access phase
  adc_dec_t                 dec;          // decode of current address
  logic                     full_word;    // byte lane 1 written
  logic [31:0]              next_prdata;  // read mux result

  // pready is registered and high in the second access cycle, so each transfer takes three cycles
  assign wr_acc    = psel & penable & pready & pwrite;
  assign rd_acc    = psel & penable & pready & ~pwrite;
  assign dec       = adc_decode(paddr);
  // the context control bits all sit in the low two lanes; a write needs lane 1 for run/wake
  assign full_word = pstrb[1];

  // apb ready: one wait state keeps prdata a flop output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  // error answer for addresses that are neither a context port nor an interrupt register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (psel & penable & ~pready)
      pslverr <= ~(dec.hit | paddr == adc_off_irq_stat | paddr == adc_off_irq_clr | paddr == adc_off_irq_en);
    else
      pslverr <= 1'b0;
  end

  // read mux, assembled per context word
  always_comb
  begin
    next_prdata = adc_word_zero;
    if (dec.hit)
    begin
      next_prdata[adc_bit_run]    = run[dec.ctx];
      next_prdata[adc_bit_wake]   = wake[dec.ctx];
      next_prdata[adc_bit_dead]   = dead[dec.ctx];
      next_prdata[adc_bit_active] = active[dec.ctx];
      next_prdata[adc_spd_lsb+:3] = spd[dec.ctx];
      next_prdata[adc_evt_lsb+:5] = evcode[dec.ctx];
    end
    else if (paddr == adc_off_irq_stat)
      next_prdata[NCTX*adc_ev_bits-1:0] = irq_stat;
    else if (paddr == adc_off_irq_en)
      next_prdata[NCTX*adc_ev_bits-1:0] = irq_en;
  end

  // read data captured in the first access cycle and held through the answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= adc_word_zero;
    else if (psel & penable & ~pready & ~pwrite)
      prdata <= next_prdata;
  end

  // one set of control and status flops per context
  generate
    for (genvar c = 0; c < NCTX; c++)
    begin : g_ctx
      logic sel;        // this context addressed by a write
      logic run_set;    // software sets run
      logic run_clr;    // software clears run
      assign sel     = wr_acc & dec.hit & (dec.ctx == 2'(c)) & full_word;
      assign run_set = sel & ~dec.clr & pwdata[adc_bit_run];
      assign run_clr = sel &  dec.clr & pwdata[adc_bit_run];

      // run changes only by software or reset
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          run[c] <= 1'b0;
        else if (soft_reset)
          run[c] <= 1'b0;
        else if (run_set)
          run[c] <= 1'b1;
        else if (run_clr)
          run[c] <= 1'b0;
      end

      // wake: set wins over a fetch in the same cycle so the request is not lost
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          wake[c] <= 1'b0;
        else if (soft_reset)
          wake[c] <= 1'b0;
        else if (sel & ~dec.clr & pwdata[adc_bit_wake])
          wake[c] <= 1'b1;
        else if (ctx_stat[c].fetch)
          wake[c] <= 1'b0;
      end

      // dead: hardware sets, cleared by software clearing run; error wins
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          dead[c] <= 1'b0;
        else if (ctx_stat[c].fatal & run[c])
          dead[c] <= 1'b1;
        else if (run_clr | soft_reset)
          dead[c] <= 1'b0;
      end

      // active mirrors the engine gated by run; it still shows for one cycle after run falls
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          active[c] <= 1'b0;
        else
          active[c] <= ctx_stat[c].busy & run[c];
      end

      // completion code updates at each finished packet, speed only when its code is legal
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          spd[c]    <= adc_spd_s100;
          evcode[c] <= adc_evt_reset;
        end
        else if (ctx_stat[c].done)
        begin
          spd[c]    <= adc_spd_legal(ctx_stat[c].spd, spd[c]);
          // engine supplies ack on success, internal error code otherwise
          evcode[c] <= ctx_stat[c].code;
        end
      end

      // controls out: start pulses on the rising edge of run
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ctx_ctrl[c] <= '0;
        else
        begin
          ctx_ctrl[c].run   <= run[c] & ~soft_reset;
          ctx_ctrl[c].wake  <= wake[c] & run[c];
          ctx_ctrl[c].start <= run_set & ~run[c] & ~soft_reset;
        end
      end

      logic [adc_ev_bits-1:0] sticky;   // this context's sticky events, kept local so one process owns them
      logic [adc_ev_bits-1:0] ev_now;   // events raised this cycle
      assign ev_now[adc_ev_dead] = ctx_stat[c].fatal & run[c] & ~dead[c];
      assign ev_now[adc_ev_done] = ctx_stat[c].done;
      assign ev_now[adc_ev_stop] = active[c] & ~(ctx_stat[c].busy & run[c]);
      assign irq_stat[c*adc_ev_bits +: adc_ev_bits] = sticky;

      // sticky events: set beats clear in the same cycle
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          sticky <= '0;
        else
        begin
          for (int e = 0; e < adc_ev_bits; e++)
          begin
            if (ev_now[e])
              sticky[e] <= 1'b1;
            else if (wr_acc & paddr == adc_off_irq_clr & pwdata[c*adc_ev_bits+e])
              sticky[e] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // enable register, plain read/write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_en <= '0;
    else if (wr_acc & paddr == adc_off_irq_en)
      irq_en <= pwdata[NCTX*adc_ev_bits-1:0];
  end

  // interrupt level registered so it is a flop output; lags status by one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_en);
  end

endmodule // adc_ctx_ctrl
`default_nettype wire

/* File: verif/adc_ctx_ctrl_props.sv */
// concurrent checks on the ports of the async context control block
// assumes one pclk domain and presetn as the only asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module adc_ctx_ctrl_props
  import adc_pkg::*;
#(
  parameter int unsigned NCTX = adc_num_ctx  // context count
)(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                soft_reset,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [3:0]          pstrb,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire adc_ctx_stat_t [3:0] ctx_stat,
  input wire adc_ctx_ctrl_t [3:0] ctx_ctrl,
  input wire logic                irq
);
  logic tk;      // transfer taken this edge
  logic ctx_rd;  // read of any context port
  logic set0;    // write at context 0 set port
  logic clr0;    // write at context 0 clear port
  assign tk     = psel && penable && pready;
  assign ctx_rd = tk && !pwrite && paddr[11:7] == 5'h03 && (paddr[4:0] == 5'h00 || paddr[4:0] == 5'h04);
  assign set0   = tk && pwrite && pstrb[1] && paddr == adc_off_txrq_set;
  assign clr0   = tk && pwrite && pstrb[1] && paddr == adc_off_txrq_clr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // exactly one wait state, then the answer
  sequence sq_one_wait;
    !pready ##1 pready;
  endsequence
  // run seen low then high at the engine side
  sequence sq_run_up;
    !ctx_ctrl[0].run ##1 ctx_ctrl[0].run;
  endsequence
  chk_one_wait: assert property (psel && !penable |=> sq_one_wait) else $error("wait state count wrong");
  chk_upper_zero: assert property (ctx_rd |-> prdata[31:16] == 16'h0000) else $error("upper half set");
  chk_mid_zero: assert property (ctx_rd |-> prdata[14:13] == 2'h0) else $error("bits 14 13 set");
  chk_low_zero: assert property (ctx_rd |-> prdata[9:8] == 2'h0) else $error("bits 9 8 set");
  chk_spd_legal: assert property (ctx_rd |-> prdata[7:5] <= 3'h2) else $error("reserved speed code");
  chk_run_cause: assert property (sq_run_up |-> $past(set0 && pwdata[15], 2)) else $error("run rose alone");
  chk_run_stop: assert property ($fell(ctx_ctrl[0].run) |-> $past(clr0 && pwdata[15], 2) ||
    $past(soft_reset)) else $error("run fell alone");
  chk_start_run: assert property ($rose(ctx_ctrl[0].run) |-> $past(ctx_ctrl[0].start)) else $error("no start");
  chk_wake_drop: assert property (ctx_stat[0].fetch && !(set0 && pwdata[12]) |-> ##2 !ctx_ctrl[0].wake)
    else $error("wake kept after fetch");
endmodule // adc_ctx_ctrl_props
bind adc_ctx_ctrl adc_ctx_ctrl_props #(.NCTX(NCTX)) adc_ctx_ctrl_props_inst (.pclk, .presetn, .soft_reset,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ctx_stat, .ctx_ctrl, .irq);
`default_nettype wire

/* File: verif/tb_adc_ctx_ctrl.sv */
// self-checking bench for the async context control block
// assumes an apb slave with one wait state and a 10 mhz pclk
`timescale 1ns/100ps
`default_nettype none
module tb_adc_ctx_ctrl;
  import adc_pkg::*;
  logic                pclk, presetn, soft_reset, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, r;
  logic [3:0]          pstrb;
  adc_ctx_stat_t [3:0] ctx_stat;  // engine reports
  adc_ctx_ctrl_t [3:0] ctx_ctrl;  // engine controls
  int                  run[4], wk[4], dd[4], ac[4], sp[4], cd[4];  // context model
  int                  ev, en, fails, tests_run, cyc, c, seed = 4510;  // event model and counters
  // free running clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  adc_ctx_ctrl adc_ctx_ctrl_inst (.pclk, .presetn, .soft_reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .ctx_stat, .ctx_ctrl, .irq);
  // one apb transfer; answer taken at the edge that sees pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0, 4'hf);
    chk(r, exp);
  endtask
  // expected control word from the model
  function automatic logic [31:0] mdl(input int k);
    return 32'((run[k] << 15) | (wk[k] << 12) | (dd[k] << 11) | (ac[k] << 10) | (sp[k] << 5) | cd[k]);
  endfunction
  function automatic logic [11:0] pa(input int k, input int cl);
    return 12'(adc_off_txrq_set + k * 32 + cl * 4);
  endfunction
  // one engine pulse {fetch, fatal, done}, then the model follows
  task automatic eng(input int k, input logic [2:0] fl, input logic [4:0] co, input logic [2:0] spd);
    adc_ctx_stat_t s;
    s = '0;
    s.busy = ac[k][0];
    @(posedge pclk);
    ctx_stat[k] <= {fl[2], 1'b0, ac[k][0], fl[1], fl[0], 1'b1, co, spd};
    @(posedge pclk);
    ctx_stat[k] <= s;
    if (fl[2]) wk[k] = 0;
    if (fl[1] && run[k] == 1) dd[k] = 1;
    if (fl[1] && run[k] == 1) ev |= 1 << (k * 3);
    if (fl[0]) cd[k] = co;
    if (fl[0] && spd <= 3'h2) sp[k] = spd;  // reserved speeds leave the field alone
    if (fl[0]) ev |= 2 << (k * 3);
  endtask
  // busy level; a fall is a went-idle event
  task automatic bsy(input int k, input logic b);
    @(posedge pclk);
    ctx_stat[k].busy <= b;
    if (ac[k] == 1 && !b) ev |= 4 << (k * 3);
    ac[k] = b;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      print_verdict();
    end
  end
  // main sequence
  initial
  begin
    {presetn, soft_reset, psel, penable, pwrite} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    ctx_stat = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (c = 0; c < 8; c++) rd(pa(c / 2, c % 2), 32'h0);
    $display("test reset values done");
    for (c = 0; c < 4; c++)
    begin
      bsy(c, 1'b1);
      apb(pa(c, 0), 1'b1, 32'hffff_ffff, 4'hf);
      run[c] = 1;
      wk[c] = 1;
      rd(pa(c, 1), mdl(c));
    end
    $display("test set ports done");
    for (c = 0; c < 4; c++)
    begin
      r = $random(seed);
      eng(c, 3'h4, 5'h0, 3'h0);
      eng(c, 3'h3, r[4:0], 3'(r[6:5] % 2'h3));
      eng(c, 3'h1, r[12:8], 3'h5);
      rd(pa(c, 0), mdl(c));
      apb(pa(c, 1), 1'b1, 32'h8000, 4'hd);  // lane 1 off, so ignored
      rd(pa(c, 0), mdl(c));
      apb(pa(c, 1), 1'b1, 32'h8000, 4'hf);
      run[c] = 0;
      dd[c] = 0;
      bsy(c, 1'b0);
      rd(pa(c, 0), mdl(c));
    end
    $display("test engine events done");
    en = 'hfff;
    apb(adc_off_irq_en, 1'b1, 32'(en), 4'hf);
    rd(adc_off_irq_stat, 32'(ev));
    chk(irq, 32'(|(ev & en)));
    apb(adc_off_irq_stat, 1'b1, 32'h0, 4'hf);  // read-only, nothing changes
    apb(adc_off_irq_clr, 1'b1, 32'hfff, 4'hf);
    ev = 0;
    rd(adc_off_irq_stat, 32'(ev));
    chk(irq, 32'(|(ev & en)));
    en = 0;
    apb(adc_off_irq_en, 1'b1, 32'(en), 4'hf);
    eng(0, 3'h1, 5'h1, 3'h0);
    rd(adc_off_irq_stat, 32'(ev));
    chk(irq, 32'(|(ev & en)));
    en = 2;
    apb(adc_off_irq_en, 1'b1, 32'(en), 4'hf);
    rd(adc_off_irq_en, 32'(en));
    chk(irq, 32'(|(ev & en)));
    $display("test interrupt done");
    rd(12'h100, 32'h0);
    chk(e, 32'h1);
    $display("test unmapped done");
    apb(pa(1, 0), 1'b1, 32'h9000, 4'hf);
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    rd(pa(1, 0), mdl(1));
    $display("test soft reset done");
    print_verdict();
  end
endmodule // tb_adc_ctx_ctrl
`default_nettype wire
